// *** logic/pip_pkg.sv ***
/*
 pip_pkg: shared constants and types of the parallel I/O port block:
 register word indices, field widths, reset values, build-time option
 enumerations and the packed state record of the block.
 Assumes a plain register port with a word index as its address.
*/
package pip_pkg;

   // register port geometry
   localparam int ADDR_W = 2;
   localparam int DATA_W = 32;
   localparam int MIN_WIDTH = 1;
   localparam int MAX_WIDTH = 32;

   // register word indices
   localparam logic [ADDR_W-1:0] REG_DATA = 2'h0;
   localparam logic [ADDR_W-1:0] REG_DIR = 2'h1;
   localparam logic [ADDR_W-1:0] REG_MASK = 2'h2;
   localparam logic [ADDR_W-1:0] REG_EDGE = 2'h3;

   // reset values
   localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_DIR = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_MASK = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_EDGE = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ALL_ONES = 32'hffff_ffff;
   localparam logic [DATA_W-1:0] ALL_ZERO = 32'h0000_0000;

   // port arrangement fixed at build time
   typedef enum {
      PIP_MODE_BIDIR,
      PIP_MODE_INPUT,
      PIP_MODE_OUTPUT,
      PIP_MODE_INOUT
   } pip_mode_type;

   // edge kind caught by the capture register
   typedef enum {
      PIP_EDGE_RISE,
      PIP_EDGE_FALL,
      PIP_EDGE_ANY
   } pip_edge_type;

   // interrupt cause
   typedef enum {
      PIP_IRQ_LEVEL,
      PIP_IRQ_EDGE
   } pip_irq_type;

   // whole state of the block
   typedef struct packed {
      logic [DATA_W-1:0] outData;
      logic [DATA_W-1:0] dir;
      logic [DATA_W-1:0] mask;
      logic [DATA_W-1:0] edgeFlag;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
      logic [DATA_W-1:0] prev;
      logic [DATA_W-1:0] rdData;
      logic [DATA_W-1:0] portOut;
      logic [DATA_W-1:0] driveN;
      logic irq;
      logic primed;
   } pip_state_type;

endpackage

// *** logic/pip_parallel_io_port.sv ***
/*
 pip_parallel_io_port: register-mapped parallel I/O port of 1 to 32 bits
 with optional edge capture and a maskable interrupt output.
 Assumes a host on the same clock that issues one-cycle read and write
 strobes on a plain register port, and pins or logic that may change at
 any time relative to sys_clk.
*/
//
// Overview of operation
// R01: port width n is a build parameter from 1 to 32 bits.
// R02: bidirectional mode uses one tristate pin per bit, direction bit chooses.
// R03: bidirectional bit set to input leaves its pin undriven.
// R04: input-only mode samples inputs and drives no output.
// R05: output-only mode drives outputs, no edge capture, no interrupt.
// R06: combined mode has separate n-bit input and output buses.
// R07: data read returns current input values, never written output value.
// R08: data write updates the stored value driven on outputs.
// R09: registers absent from the build ignore writes, read as anything.
// R10: edge capture catches rising, falling or either edge, chosen at build.
// R11: a selected edge on an input sets that bit's edge flag.
// R12: edge kind fixed at build, no register can change it.
// R13: edge flag register exists only with edge capture built in.
// R14: level interrupt asserts while any enabled input is high.
// R15: edge interrupt asserts while any enabled edge flag is set.
// R16: a per-bit enable register masks interrupts per input.
// R17: enable register exists only when interrupts are built in.
// R18: one slave port with plain single reads and writes only.
// R19: one interrupt request output beside the slave port.
// R20: registers 32 bits wide at word indices 0, 1, 2 and 3.
// R21: any write to the edge flag register clears all its bits.
// R22: reset clears every direction bit and every enable bit.
// R23: interrupt holds until enables are cleared or edge flags written.
// R24: edges found by comparing successive samples; new edge beats clear.
`timescale 1ns/1ps

module pip_parallel_io_port
   import pip_pkg::*;
#(
   // R01: build-time width
   parameter int unsigned WIDTH = 32,
   parameter pip_mode_type MODE = PIP_MODE_BIDIR,
   parameter bit CAPTURE_EN = 1'b1,
   parameter pip_edge_type EDGE_KIND = PIP_EDGE_RISE,
   parameter bit IRQ_EN = 1'b1,
   parameter pip_irq_type IRQ_KIND = PIP_IRQ_EDGE
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   output logic irq,
   input wire logic [WIDTH-1:0] portIn,
   output logic [WIDTH-1:0] portOut,
   output logic [WIDTH-1:0] portDriveN
);

   // build-time feature decode
   localparam logic [DATA_W-1:0] WMASK = ALL_ONES >> (DATA_W - int'(WIDTH));
   localparam bit IN_ON = (MODE != PIP_MODE_OUTPUT);
   localparam bit OUT_ON = (MODE != PIP_MODE_INPUT);
   localparam bit DIR_ON = (MODE == PIP_MODE_BIDIR);
   // R05: output-only builds drop capture and interrupt
   localparam bit CAP_ON = CAPTURE_EN && IN_ON;
   localparam bit IRQ_ON = IRQ_EN && IN_ON;

   // separate output bus is driven from reset on, so no false release after it
   localparam pip_state_type ST_RESET = '{
      outData: RST_DATA,
      dir: RST_DIR,
      mask: RST_MASK,
      edgeFlag: RST_EDGE,
      sync1: ALL_ZERO,
      sync2: ALL_ZERO,
      prev: ALL_ZERO,
      rdData: ALL_ZERO,
      portOut: ALL_ZERO,
      driveN: (OUT_ON && !DIR_ON) ? ALL_ZERO : ALL_ONES,
      irq: 1'b0,
      primed: 1'b0
   };

   pip_state_type st_r;
   pip_state_type st_nxt;
   logic [DATA_W-1:0] edgeHit;
   logic edgeClear;

   // R09: which registers the build holds; used by read and write paths
   function automatic logic regPresent(input logic [ADDR_W-1:0] addr);
      logic ok;
      ok = 1'b0;
      // R20: word indices 0 to 3
      case (addr)
         REG_DATA: ok = 1'b1;
         REG_DIR: ok = DIR_ON;
         // R17: enables need interrupts
         REG_MASK: ok = IRQ_ON;
         REG_EDGE: ok = CAP_ON;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // R12: edge kind is a constant, not a register field
   function automatic logic [DATA_W-1:0] edgeSel(
      input logic [DATA_W-1:0] cur,
      input logic [DATA_W-1:0] old
   );
      logic [DATA_W-1:0] hit;
      hit = ALL_ZERO;
      case (EDGE_KIND)
         PIP_EDGE_RISE: hit = cur & ~old;
         PIP_EDGE_FALL: hit = ~cur & old;
         PIP_EDGE_ANY: hit = cur ^ old;
         default: hit = ALL_ZERO;
      endcase
      return hit;
   endfunction

   // R10: compare each synchronised sample with the one before it
   // only the first cycle after reset is masked; the first input sample is compared with the reset zero
   assign edgeHit = (CAP_ON && st_r.primed) ? (edgeSel(st_r.sync2, st_r.prev) & WMASK)
                                            : ALL_ZERO;
   assign edgeClear = regWr && (regAddr == REG_EDGE) && regPresent(regAddr);

   always_comb begin
      st_nxt = st_r;

      // two-stage synchroniser; upper unused bits stay zero
      st_nxt.sync1 = DATA_W'(portIn) & WMASK;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.prev = st_r.sync2;
      st_nxt.primed = 1'b1;

      // R18: one-cycle read answer, zero when no read
      st_nxt.rdData = ALL_ZERO;
      if (regRd && regPresent(regAddr)) begin
         case (regAddr)
            // R07: inputs only, the output latch is never read back
            REG_DATA: st_nxt.rdData = IN_ON ? st_r.sync2 : ALL_ZERO;
            REG_DIR: st_nxt.rdData = st_r.dir;
            REG_MASK: st_nxt.rdData = st_r.mask;
            REG_EDGE: st_nxt.rdData = st_r.edgeFlag;
            default: st_nxt.rdData = ALL_ZERO;
         endcase
      end

      // R09: writes to absent registers fall through here untouched
      if (regWr && regPresent(regAddr)) begin
         case (regAddr)
            // R08: store value for the outputs
            REG_DATA: begin
               if (OUT_ON) begin
                  st_nxt.outData = regWrData & WMASK;
               end
            end
            REG_DIR: st_nxt.dir = regWrData & WMASK;
            // R16: per-bit interrupt enables
            REG_MASK: st_nxt.mask = regWrData & WMASK;
            default: st_nxt.outData = st_nxt.outData;
         endcase
      end

      // R11: set flags on selected edges
      // R21: any write to the edge flag register clears all flags
      // R24: a fresh edge survives a clear in the same cycle
      if (CAP_ON) begin
         st_nxt.edgeFlag = (edgeClear ? ALL_ZERO : st_r.edgeFlag) | edgeHit;
      end else begin
         // R13: no flag storage without capture
         st_nxt.edgeFlag = ALL_ZERO;
      end

      // R19: single interrupt line, one cycle behind its cause
      st_nxt.irq = 1'b0;
      if (IRQ_ON) begin
         if (IRQ_KIND == PIP_IRQ_LEVEL) begin
            // R14: enabled input high
            st_nxt.irq = |(st_r.sync2 & st_r.mask);
         end else begin
            // R15: enabled edge flag set; R23: held until acknowledged
            st_nxt.irq = |(st_r.edgeFlag & st_r.mask);
         end
      end

      // pin drivers follow the next state so they never lag the registers
      case (MODE)
         PIP_MODE_BIDIR: begin
            // R02: direction bit picks drive or sample
            // R03: input bits released
            st_nxt.portOut = st_nxt.outData;
            st_nxt.driveN = ~st_nxt.dir & WMASK;
         end
         PIP_MODE_INPUT: begin
            // R04: nothing driven
            st_nxt.portOut = ALL_ZERO;
            st_nxt.driveN = WMASK;
         end
         PIP_MODE_OUTPUT, PIP_MODE_INOUT: begin
            // R06: separate output bus always driven
            st_nxt.portOut = st_nxt.outData;
            st_nxt.driveN = ALL_ZERO;
         end
         default: begin
            st_nxt.portOut = ALL_ZERO;
            st_nxt.driveN = WMASK;
         end
      endcase
   end

   // R22: reset clears direction and enables
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdData = st_r.rdData;
   assign irq = st_r.irq;
   assign portOut = st_r.portOut[WIDTH-1:0];
   assign portDriveN = st_r.driveN[WIDTH-1:0];

   // checks kept beside the logic

   property p_width_legal;
      @(posedge sys_clk) disable iff (rst)
      (WIDTH >= MIN_WIDTH) && (WIDTH <= MAX_WIDTH) && ((st_r.sync2 & ~WMASK) == ALL_ZERO);
   endproperty
   a_width_legal: assert property (p_width_legal) else $error("port width out of range"); // R01

   property p_bidir_pins;
      @(posedge sys_clk) disable iff (rst)
      (MODE == PIP_MODE_BIDIR) |->
         (portDriveN == ~st_r.dir[WIDTH-1:0]) && (portOut == st_r.outData[WIDTH-1:0]);
   endproperty
   a_bidir_pins: assert property (p_bidir_pins) else $error("bidir pin drive wrong"); // R02

   property p_dir_write_release;
      @(posedge sys_clk) disable iff (rst)
      (DIR_ON && regWr && regAddr == REG_DIR) |=>
         (portDriveN == ~$past(regWrData[WIDTH-1:0]));
   endproperty
   a_dir_write_release: assert property (p_dir_write_release) else $error("dir write not on pins"); // R03

   property p_input_only;
      @(posedge sys_clk) disable iff (rst)
      (MODE == PIP_MODE_INPUT) |-> (&portDriveN) && (portOut == '0) && (st_r.outData == RST_DATA);
   endproperty
   a_input_only: assert property (p_input_only) else $error("input-only build drives"); // R04

   property p_output_only;
      @(posedge sys_clk) disable iff (rst)
      (MODE == PIP_MODE_OUTPUT) |-> !irq && (st_r.edgeFlag == ALL_ZERO) && (portDriveN == '0);
   endproperty
   a_output_only: assert property (p_output_only) else $error("output-only has input features"); // R05

   property p_inout_bus;
      @(posedge sys_clk) disable iff (rst)
      (MODE == PIP_MODE_INOUT) |-> (portDriveN == '0) && (portOut == st_r.outData[WIDTH-1:0]);
   endproperty
   a_inout_bus: assert property (p_inout_bus) else $error("separate output bus wrong"); // R06

   property p_data_read;
      @(posedge sys_clk) disable iff (rst)
      (regRd && regAddr == REG_DATA && IN_ON) |=> (regRdData == $past(st_r.sync2));
   endproperty
   a_data_read: assert property (p_data_read) else $error("data read not input value"); // R07

   property p_data_write;
      @(posedge sys_clk) disable iff (rst)
      (OUT_ON && regWr && regAddr == REG_DATA && MODE != PIP_MODE_BIDIR) |=>
         (portOut == $past(regWrData[WIDTH-1:0]));
   endproperty
   a_data_write: assert property (p_data_write) else $error("data write not on outputs"); // R08

   property p_absent_dir;
      @(posedge sys_clk) disable iff (rst)
      !DIR_ON |-> (st_r.dir == RST_DIR);
   endproperty
   a_absent_dir: assert property (p_absent_dir) else $error("absent dir register changed"); // R09

   property p_edge_source;
      @(posedge sys_clk) disable iff (rst)
      CAP_ON |=> ((st_r.edgeFlag & ~$past(st_r.edgeFlag) & ~$past(edgeHit)) == ALL_ZERO);
   endproperty
   a_edge_source: assert property (p_edge_source) else $error("flag set without edge"); // R10

   property p_edge_sets;
      @(posedge sys_clk) disable iff (rst)
      (edgeHit != ALL_ZERO) |=> ((st_r.edgeFlag & $past(edgeHit)) == $past(edgeHit));
   endproperty
   a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag"); // R11

   property p_rise_only;
      @(posedge sys_clk) disable iff (rst)
      (CAP_ON && EDGE_KIND == PIP_EDGE_RISE && st_r.primed) |->
         ((edgeHit & ~st_r.sync2) == ALL_ZERO) && ((edgeHit & st_r.prev) == ALL_ZERO);
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("non-rising edge caught"); // R12

   property p_absent_edge;
      @(posedge sys_clk) disable iff (rst)
      !CAP_ON |-> (st_r.edgeFlag == ALL_ZERO);
   endproperty
   a_absent_edge: assert property (p_absent_edge) else $error("edge flags without capture"); // R13

   property p_level_irq;
      @(posedge sys_clk) disable iff (rst)
      (IRQ_ON && IRQ_KIND == PIP_IRQ_LEVEL) |=> (irq == |($past(st_r.sync2) & $past(st_r.mask)));
   endproperty
   a_level_irq: assert property (p_level_irq) else $error("level interrupt wrong"); // R14

   property p_edge_irq;
      @(posedge sys_clk) disable iff (rst)
      (IRQ_ON && IRQ_KIND == PIP_IRQ_EDGE) |=>
         (irq == |($past(st_r.edgeFlag) & $past(st_r.mask)));
   endproperty
   a_edge_irq: assert property (p_edge_irq) else $error("edge interrupt wrong"); // R15

   property p_mask_write;
      @(posedge sys_clk) disable iff (rst)
      (IRQ_ON && regWr && regAddr == REG_MASK) |=> (st_r.mask == ($past(regWrData) & WMASK));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("enable write lost"); // R16

   property p_absent_mask;
      @(posedge sys_clk) disable iff (rst)
      !IRQ_ON |-> (st_r.mask == RST_MASK) && !irq;
   endproperty
   a_absent_mask: assert property (p_absent_mask) else $error("enables without interrupt"); // R17

   property p_read_one_cycle;
      @(posedge sys_clk) disable iff (rst)
      !regRd |=> (regRdData == ALL_ZERO);
   endproperty
   a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data stayed"); // R18

   property p_upper_zero;
      @(posedge sys_clk) disable iff (rst)
      regRd |=> ((regRdData & ~WMASK) == ALL_ZERO);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("bits above width nonzero"); // R20

   property p_edge_clear;
      @(posedge sys_clk) disable iff (rst)
      edgeClear |=> (st_r.edgeFlag == $past(edgeHit));
   endproperty
   a_edge_clear: assert property (p_edge_clear) else $error("edge clear wrong"); // R21

   property p_reset_values;
      @(posedge sys_clk) disable iff (rst)
      $past(rst) |-> (st_r.dir == RST_DIR) && (st_r.mask == RST_MASK) && !irq;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // R22

   property p_irq_hold;
      @(posedge sys_clk) disable iff (rst)
      (IRQ_ON && IRQ_KIND == PIP_IRQ_EDGE && ((st_r.edgeFlag & st_r.mask) != ALL_ZERO)
         && !regWr) |=> irq ##1 irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped unasked"); // R23

   property p_set_beats_clear;
      @(posedge sys_clk) disable iff (rst)
      (edgeClear && edgeHit != ALL_ZERO) |=> (st_r.edgeFlag != ALL_ZERO);
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear) else $error("edge lost to clear"); // R24

endmodule // pip_parallel_io_port

// *** testbench/pip_pin_model.sv ***
/*
 pip_pin_model: far side of the bidirectional port pins.
 Assumes an active-low per-bit drive enable from the block; an outside
 device drives each pin only while the block has released it.
*/
`timescale 1ns/1ps

module pip_pin_model #(
   parameter int W = 8
) (
   input wire logic [W-1:0] portOut,
   input wire logic [W-1:0] portDriveN,
   input wire logic [W-1:0] extDrive,
   output logic [W-1:0] pinLevel
);

   always_comb begin
      for (int i = 0; i < W; i++) begin
         // released bit: outside device wins
         pinLevel[i] = portDriveN[i] ? extDrive[i] : portOut[i];
      end
   end

endmodule // pip_pin_model

// *** testbench/pip_parallel_io_port_tb.sv ***
/*
 pip_parallel_io_port_tb: self-checking bench of the parallel I/O port,
 bidirectional, rising-edge capture, edge interrupt, 8 bits wide; a second
 build with separate buses, either-edge capture and level interrupt.
 Assumes the pin model closes the loop from portOut to portIn.
*/
`timescale 1ns/1ps

module pip_parallel_io_port_tb;
   import pip_pkg::*;

   localparam int W = 8;
   localparam logic [DATA_W-1:0] MSK = 32'h0000_00ff;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] regAddr = 2'h0;
   logic [DATA_W-1:0] regWrData = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [DATA_W-1:0] regRdData;
   logic irq;
   logic [W-1:0] portIn;
   logic [W-1:0] portOut;
   logic [W-1:0] portDriveN;
   logic [W-1:0] extDrive = 8'h00;
   logic [DATA_W-1:0] rdB;
   logic irqB;
   logic [W-1:0] inB = 8'h00;
   logic [W-1:0] outB;
   logic [W-1:0] driveNB;
   logic [31:0] dB;
   logic [31:0] seed = 32'h0001_092e;
   logic [31:0] v, d, m, outV, dirV;
   int errorCnt = 0;
   int checkCount = 0;

   always #5 sys_clk = ~sys_clk;

   pip_parallel_io_port #(
      .WIDTH(W),
      .MODE(PIP_MODE_BIDIR),
      .CAPTURE_EN(1'b1),
      .EDGE_KIND(PIP_EDGE_RISE),
      .IRQ_EN(1'b1),
      .IRQ_KIND(PIP_IRQ_EDGE)
   ) i_pip_parallel_io_port (
      .sys_clk(sys_clk),
      .rst(rst),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regWr(regWr),
      .regRd(regRd),
      .regRdData(regRdData),
      .irq(irq),
      .portIn(portIn),
      .portOut(portOut),
      .portDriveN(portDriveN)
   );

   pip_pin_model #(
      .W(W)
   ) i_pip_pin_model (
      .portOut(portOut),
      .portDriveN(portDriveN),
      .extDrive(extDrive),
      .pinLevel(portIn)
   );

   pip_parallel_io_port #(
      .WIDTH(W),
      .MODE(PIP_MODE_INOUT),
      .CAPTURE_EN(1'b1),
      .EDGE_KIND(PIP_EDGE_ANY),
      .IRQ_EN(1'b1),
      .IRQ_KIND(PIP_IRQ_LEVEL)
   ) i_pip_parallel_io_port_b (
      .sys_clk(sys_clk),
      .rst(rst),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regWr(regWr),
      .regRd(regRd),
      .regRdData(rdB),
      .irq(irqB),
      .portIn(inB),
      .portOut(outB),
      .portDriveN(driveNB)
   );

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // driven bits show the latch, released bits the outside level
   function automatic logic [31:0] pinExp(logic [31:0] e, logic [31:0] o, logic [31:0] r);
      return ((r & o) | (~r & e)) & MSK;
   endfunction

   task check(input logic [31:0] g, input logic [31:0] e);
      checkCount++;
      if (g !== e) begin
         errorCnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task wr(input logic [1:0] a, input logic [31:0] dd);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= dd;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   task rd(input logic [1:0] a, output logic [31:0] dd);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      dd = regRdData;
      dB = rdB;
   endtask

   // four edges cover the two-flop sampling and compare
   task pins(input logic [31:0] e);
      @(posedge sys_clk);
      extDrive <= e[W-1:0];
      inB <= e[W-1:0];
      repeat (4) @(posedge sys_clk);
      // look after the edge has settled
      #1;
   endtask

   task waitIrq(input logic e);
      int n;
      n = 0;
      while (irq !== e && n < 8) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check({31'h0, irq}, {31'h0, e});
   endtask

   task closeOut();
      $display("checks %0d mismatches %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge sys_clk);
      errorCnt++;
      closeOut();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rd(REG_DIR, d);
      check(d, 32'h0000_0000);
      rd(REG_MASK, d);
      check(d, 32'h0000_0000);
      rd(REG_EDGE, d);
      check(d, 32'h0000_0000);
      check({24'h0, portDriveN}, MSK);
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         v = xs();
         pins(v);
         rd(REG_DATA, d);
         check(d, v & MSK);
      end
      $display("input read test done");
      for (int i = 0; i < 6; i++) begin
         outV = xs();
         dirV = (i == 0) ? 32'hffff_ffff : xs();
         v = ~outV;
         wr(REG_DATA, outV);
         wr(REG_DIR, dirV);
         pins(v);
         check({24'h0, portOut & ~portDriveN}, outV & dirV & MSK);
         check({24'h0, portDriveN}, ~dirV & MSK);
         rd(REG_DIR, d);
         check(d, dirV & MSK);
         rd(REG_DATA, d);
         check(d, pinExp(v, outV, dirV));
      end
      $display("output test done");
      wr(REG_DIR, 32'h0000_0000);
      pins(32'h0);
      wr(REG_EDGE, xs());
      rd(REG_EDGE, d);
      check(d, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? MSK : xs();
         pins(v);
         rd(REG_EDGE, d);
         check(d, v & MSK);
         pins(32'h0);
         rd(REG_EDGE, d);
         check(d, v & MSK);
         wr(REG_EDGE, xs());
         rd(REG_EDGE, d);
         check(d, 32'h0000_0000);
      end
      $display("edge test done");
      for (int i = 0; i < 4; i++) begin
         m = 32'h0000_0001 << (xs() % W);
         wr(REG_MASK, m);
         rd(REG_MASK, d);
         check(d, m);
         pins(~m & MSK);
         check({31'h0, irq}, 32'h0);
         pins(MSK);
         waitIrq(1'b1);
         repeat (3) @(posedge sys_clk);
         check({31'h0, irq}, 32'h1);
         if (i % 2 == 0) begin
            wr(REG_MASK, 32'h0000_0000);
         end else begin
            wr(REG_EDGE, 32'h0000_0000);
         end
         waitIrq(1'b0);
         pins(32'h0);
         wr(REG_EDGE, 32'h0000_0000);
         wr(REG_MASK, 32'h0000_0000);
      end
      $display("interrupt test done");
      // second build: separate buses, either edge, level interrupt
      check({24'h0, driveNB}, 32'h0000_0000);
      outV = xs();
      wr(REG_DATA, outV);
      #1;
      check({24'h0, outB}, outV & MSK);
      v = xs();
      pins(MSK);
      wr(REG_EDGE, 32'h0000_0000);
      pins(v);
      rd(REG_EDGE, d);
      check(dB, ~v & MSK);
      rd(REG_DATA, d);
      check(dB, v & MSK);
      m = 32'h0000_0001 << (xs() % W);
      wr(REG_MASK, m);
      pins(m);
      check({31'h0, irqB}, 32'h0000_0001);
      pins(~m & MSK);
      check({31'h0, irqB}, 32'h0000_0000);
      $display("second build test done");
      closeOut();
   end

endmodule // pip_parallel_io_port_tb
